/* hdl/tcd_dma_ctrl.sv */
// Two-channel DMA controller with wait-state control behind an APB slave
// What this block does
// - Channel 0 byte count is 16 bits, low byte 0x26, high byte 0x27.
// - Channel 1 memory address in bytes 0x28-0x2a; bank keeps bits 0-2.
// - Channel 1 I/O address is 16 bits at 0x2b low, 0x2c high.
// - Channel 1 byte count is 16 bits at 0x2e low, 0x2f high.
// - Per-channel enable resets 0; write-only gate bit controls its alteration.
// - Per-channel interrupt enable, resets 0, permits that channel's interrupt.
// - Channel 0 destination and source mode fields, two bits, reset 00.
// - Memory cycles get 0-3 wait states from their field; resets 11.
// - I/O cycles get 0, 2, 3 or 4 wait states; field resets 11.
// - Sense bit 1 picks edge, 0 level detection per request; resets 0.
// - Channel 1 direction: mem-to-I/O or I/O-to-mem, memory inc/dec, I/O fixed.
// - Source bank bits 0-2; bank 0/1 low bits pick external or serial receive.
// - Dest bank bits 0-2; bank 0/1 low bits pick external or serial transmit.
`timescale 1ns/1ns
`default_nettype none

module tcd_dma_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] transfer_request_input,
  input wire logic [1:0] serial_rx_ready,
  input wire logic [1:0] serial_tx_ready,
  input wire logic master_halt,
  output tcd_pkg::tcd_bus_t bus,
  input wire logic [7:0] bus_rdata,
  output logic irq
);

  if (ADDR_W < 8) begin : g_bad_addr
    $error("tcd_dma_ctrl: ADDR_W must be at least 8");
  end

  tcd_pkg::tcd_state_t r_reg;
  tcd_pkg::tcd_state_t r_next;
  logic [1:0] req_pending;

  for (genvar i = 0; i < 2; i++) begin : g_sense
    tcd_req_sense u_sense (
      .pclk(pclk),
      .presetn(presetn),
      .req_pin(transfer_request_input[i]),
      .edge_mode(r_reg.sense[i]),
      .consume(r_reg.consume[i]),
      .pending(req_pending[i])
    );
  end

  // Memory address step: only increment and decrement modes move it
  function automatic logic [tcd_pkg::MEM_ADDR_W-1:0] step_addr(
      input logic [tcd_pkg::MEM_ADDR_W-1:0] a, input logic [1:0] mode);
    case (mode)
      tcd_pkg::AMODE_INC: return a + 19'h1;
      tcd_pkg::AMODE_DEC: return a - 19'h1;
      default: return a;
    endcase
  endfunction

  function automatic logic [tcd_pkg::MEM_ADDR_W-1:0] set_byte(
      input logic [tcd_pkg::MEM_ADDR_W-1:0] a, input logic [1:0] lane, input logic [7:0] d);
    logic [tcd_pkg::MEM_ADDR_W-1:0] t;
    t = a;
    case (lane)
      2'd0: t[7:0] = d;
      2'd1: t[15:8] = d;
      default: t[18:16] = d[2:0];
    endcase
    return t;
  endfunction

  // Register read view; hit is low for unmapped indices
  function automatic logic [8:0] read_byte(input tcd_pkg::tcd_state_t s, input logic [5:0] idx);
    logic [7:0] d;
    logic hit;
    d = 8'h00;
    hit = 1'b1;
    case (idx)
      tcd_pkg::IDX_CH0_SRC_LOW: d = s.ch0_src[7:0];
      tcd_pkg::IDX_CH0_SRC_HIGH: d = s.ch0_src[15:8];
      tcd_pkg::IDX_CH0_SRC_BANK: d = {5'h00, s.ch0_src[18:16]};
      tcd_pkg::IDX_CH0_DEST_LOW: d = s.ch0_dest[7:0];
      tcd_pkg::IDX_CH0_DEST_HIGH: d = s.ch0_dest[15:8];
      tcd_pkg::IDX_CH0_DEST_BANK: d = {5'h00, s.ch0_dest[18:16]};
      tcd_pkg::IDX_CH0_COUNT_LOW: d = s.ch0_count[7:0];
      tcd_pkg::IDX_CH0_COUNT_HIGH: d = s.ch0_count[15:8];
      tcd_pkg::IDX_CH1_MEM_LOW: d = s.ch1_mem[7:0];
      tcd_pkg::IDX_CH1_MEM_HIGH: d = s.ch1_mem[15:8];
      tcd_pkg::IDX_CH1_MEM_BANK: d = {5'h00, s.ch1_mem[18:16]};
      tcd_pkg::IDX_CH1_IO_LOW: d = s.ch1_io[7:0];
      tcd_pkg::IDX_CH1_IO_HIGH: d = s.ch1_io[15:8];
      tcd_pkg::IDX_CH1_COUNT_LOW: d = s.ch1_count[7:0];
      tcd_pkg::IDX_CH1_COUNT_HIGH: d = s.ch1_count[15:8];
      tcd_pkg::IDX_STATUS_ENABLE: begin
        // Gate bits are write-only and read back as ones
        d = tcd_pkg::STATUS_RESET;
        d[tcd_pkg::ST_CH1_ENABLE] = s.enable[1];
        d[tcd_pkg::ST_CH0_ENABLE] = s.enable[0];
        d[tcd_pkg::ST_CH1_IRQ_EN] = s.irq_en[1];
        d[tcd_pkg::ST_CH0_IRQ_EN] = s.irq_en[0];
        d[tcd_pkg::ST_MASTER] = s.master;
      end
      tcd_pkg::IDX_CH0_MODE: begin
        d = tcd_pkg::CH0_MODE_RESET;
        d[tcd_pkg::MODE_DEST_LSB +: 2] = s.dest_mode;
        d[tcd_pkg::MODE_SRC_LSB +: 2] = s.src_mode;
        d[tcd_pkg::MODE_STYLE_BIT] = s.style;
      end
      tcd_pkg::IDX_WAIT_REQ_CTRL: begin
        d[tcd_pkg::CTL_MEM_WAIT_LSB +: 2] = s.mem_wait;
        d[tcd_pkg::CTL_IO_WAIT_LSB +: 2] = s.io_wait;
        d[tcd_pkg::CTL_SENSE_LSB +: 2] = s.sense;
        d[tcd_pkg::CTL_DIR_LSB +: 2] = s.dir;
      end
      tcd_pkg::IDX_IRQ_STATUS: d = {6'h00, s.done};
      tcd_pkg::IDX_IRQ_CLEAR: d = 8'h00;
      tcd_pkg::IDX_IRQ_ENABLE: d = {6'h00, s.irq_en};
      default: hit = 1'b0;
    endcase
    return {hit, d};
  endfunction

  always_comb begin
    logic [5:0] idx;
    logic [8:0] rd;
    logic addr_ok;
    logic do_write;
    logic [7:0] w;
    logic io_src0;
    logic io_dst0;
    logic paced0;
    logic [2:0] bank0;
    logic req0;
    logic go0;
    logic go1;
    logic pick;
    logic src_io;
    logic dst_io;
    logic [tcd_pkg::MEM_ADDR_W-1:0] src_addr;
    logic [tcd_pkg::MEM_ADDR_W-1:0] dst_addr;
    logic [15:0] cnt_left;
    logic [1:0] done_set;
    logic [1:0] done_clr;
    r_next = r_reg;
    idx = paddr[7:2];
    // Address bits above the register window must be clear, so nothing aliases
    addr_ok = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);
    rd = read_byte(r_reg, idx);
    do_write = psel && penable && pwrite;
    w = pwdata[7:0];
    r_next.consume = 2'b00;
    done_set = 2'b00;
    done_clr = 2'b00;
    cnt_left = 16'h0000;
    src_io = 1'b0;
    dst_io = 1'b0;
    src_addr = '0;
    dst_addr = '0;

    // Read data and error are latched in the setup phase
    if (psel && !penable) begin
      r_next.prdata = (addr_ok && rd[8]) ? {24'h000000, rd[7:0]} : 32'h00000000;
      r_next.pslverr = !(addr_ok && rd[8]);
    end

    // Channel 0 pacing: an I/O end is paced by the source its bank selects
    io_src0 = r_reg.src_mode == tcd_pkg::AMODE_IO;
    io_dst0 = r_reg.dest_mode == tcd_pkg::AMODE_IO;
    paced0 = io_src0 || io_dst0;
    bank0 = io_src0 ? r_reg.ch0_src[18:16] : r_reg.ch0_dest[18:16];
    // A paced end whose bank has bit 2 set has no request source at all
    req0 = 1'b0;
    if (!paced0) begin
      req0 = 1'b1;
    end else if (!bank0[2]) begin
      case (bank0[1:0])
        tcd_pkg::RSRC_EXT: req0 = req_pending[0];
        tcd_pkg::RSRC_SER0: req0 = io_src0 ? serial_rx_ready[0] : serial_tx_ready[0];
        tcd_pkg::RSRC_SER1: req0 = io_src0 ? serial_rx_ready[1] : serial_tx_ready[1];
        default: req0 = 1'b0;
      endcase
    end
    go0 = r_reg.master && r_reg.enable[0] && req0;
    go1 = r_reg.master && r_reg.enable[1] && req_pending[1];
    // Channel 0 wins a tie; channel 1 waits for the next idle slot
    pick = (r_reg.fsm == tcd_pkg::TCD_IDLE) ? !go0 : r_reg.chan;

    if (!pick) begin
      src_io = io_src0;
      dst_io = io_dst0;
      src_addr = r_reg.ch0_src;
      dst_addr = r_reg.ch0_dest;
    end else begin
      // Memory-to-I/O when the direction's high bit is clear
      src_io = r_reg.dir[1];
      dst_io = !r_reg.dir[1];
      src_addr = r_reg.dir[1] ? {3'b000, r_reg.ch1_io} : r_reg.ch1_mem;
      dst_addr = r_reg.dir[1] ? r_reg.ch1_mem : {3'b000, r_reg.ch1_io};
    end

    case (r_reg.fsm)
      tcd_pkg::TCD_IDLE: begin
        if (go0 || go1) begin
          r_next.chan = pick;
          r_next.fsm = tcd_pkg::TCD_READ;
          r_next.bus = '{valid: 1'b1, is_io: src_io, write: 1'b0, addr: src_addr,
                         wdata: 8'h00};
          r_next.wait_cnt = tcd_pkg::cycle_waits(src_io, r_reg.mem_wait, r_reg.io_wait);
        end
      end
      tcd_pkg::TCD_READ: begin
        if (r_reg.wait_cnt != 3'd0) begin
          r_next.wait_cnt = r_reg.wait_cnt - 3'd1;
        end else begin
          r_next.fsm = tcd_pkg::TCD_WRITE;
          r_next.bus = '{valid: 1'b1, is_io: dst_io, write: 1'b1, addr: dst_addr,
                         wdata: bus_rdata};
          r_next.wait_cnt = tcd_pkg::cycle_waits(dst_io, r_reg.mem_wait, r_reg.io_wait);
        end
      end
      tcd_pkg::TCD_WRITE: begin
        if (r_reg.wait_cnt != 3'd0) begin
          r_next.wait_cnt = r_reg.wait_cnt - 3'd1;
        end else begin
          r_next.bus = '0;
          if (!r_reg.chan) begin
            r_next.ch0_src = step_addr(r_reg.ch0_src, r_reg.src_mode);
            r_next.ch0_dest = step_addr(r_reg.ch0_dest, r_reg.dest_mode);
            cnt_left = r_reg.ch0_count - 16'h0001;
            r_next.ch0_count = cnt_left;
            r_next.consume[0] = paced0 && !bank0[2] && (bank0[1:0] == tcd_pkg::RSRC_EXT);
            // Unpaced cycle steal adds a YIELD cycle before idle; burst and paced transfers go straight to idle
            r_next.fsm = (!paced0 && !r_reg.style) ? tcd_pkg::TCD_YIELD : tcd_pkg::TCD_IDLE;
          end else begin
            r_next.ch1_mem = step_addr(r_reg.ch1_mem, {1'b0, r_reg.dir[0]});
            cnt_left = r_reg.ch1_count - 16'h0001;
            r_next.ch1_count = cnt_left;
            r_next.consume[1] = 1'b1;
            r_next.fsm = tcd_pkg::TCD_IDLE;
          end
          // A start count of zero wraps and runs the full 65536 bytes
          if (cnt_left == 16'h0000) begin
            r_next.enable[r_reg.chan] = 1'b0;
            done_set[r_reg.chan] = 1'b1;
            r_next.fsm = tcd_pkg::TCD_IDLE;
          end
        end
      end
      tcd_pkg::TCD_YIELD: r_next.fsm = tcd_pkg::TCD_IDLE;
      default: r_next.fsm = tcd_pkg::TCD_IDLE;
    endcase

    // Software writes land after the engine update and win over it, except that a done clear loses to a completion
    if (do_write && addr_ok) begin
      case (idx)
        tcd_pkg::IDX_CH0_SRC_LOW: r_next.ch0_src = set_byte(r_next.ch0_src, 2'd0, w);
        tcd_pkg::IDX_CH0_SRC_HIGH: r_next.ch0_src = set_byte(r_next.ch0_src, 2'd1, w);
        tcd_pkg::IDX_CH0_SRC_BANK: r_next.ch0_src = set_byte(r_next.ch0_src, 2'd2, w);
        tcd_pkg::IDX_CH0_DEST_LOW: r_next.ch0_dest = set_byte(r_next.ch0_dest, 2'd0, w);
        tcd_pkg::IDX_CH0_DEST_HIGH: r_next.ch0_dest = set_byte(r_next.ch0_dest, 2'd1, w);
        tcd_pkg::IDX_CH0_DEST_BANK: r_next.ch0_dest = set_byte(r_next.ch0_dest, 2'd2, w);
        tcd_pkg::IDX_CH0_COUNT_LOW: r_next.ch0_count[7:0] = w;
        tcd_pkg::IDX_CH0_COUNT_HIGH: r_next.ch0_count[15:8] = w;
        tcd_pkg::IDX_CH1_MEM_LOW: r_next.ch1_mem = set_byte(r_next.ch1_mem, 2'd0, w);
        tcd_pkg::IDX_CH1_MEM_HIGH: r_next.ch1_mem = set_byte(r_next.ch1_mem, 2'd1, w);
        tcd_pkg::IDX_CH1_MEM_BANK: r_next.ch1_mem = set_byte(r_next.ch1_mem, 2'd2, w);
        tcd_pkg::IDX_CH1_IO_LOW: r_next.ch1_io[7:0] = w;
        tcd_pkg::IDX_CH1_IO_HIGH: r_next.ch1_io[15:8] = w;
        tcd_pkg::IDX_CH1_COUNT_LOW: r_next.ch1_count[7:0] = w;
        tcd_pkg::IDX_CH1_COUNT_HIGH: r_next.ch1_count[15:8] = w;
        tcd_pkg::IDX_STATUS_ENABLE: begin
          // A gate bit written as 0 lets its enable bit change in the same write
          if (!w[tcd_pkg::ST_CH1_GATE]) begin
            r_next.enable[1] = w[tcd_pkg::ST_CH1_ENABLE];
          end
          if (!w[tcd_pkg::ST_CH0_GATE]) begin
            r_next.enable[0] = w[tcd_pkg::ST_CH0_ENABLE];
          end
          if ((!w[tcd_pkg::ST_CH1_GATE] && w[tcd_pkg::ST_CH1_ENABLE]) ||
              (!w[tcd_pkg::ST_CH0_GATE] && w[tcd_pkg::ST_CH0_ENABLE])) begin
            r_next.master = 1'b1;
          end
          r_next.irq_en = {w[tcd_pkg::ST_CH1_IRQ_EN], w[tcd_pkg::ST_CH0_IRQ_EN]};
        end
        tcd_pkg::IDX_CH0_MODE: begin
          r_next.dest_mode = w[tcd_pkg::MODE_DEST_LSB +: 2];
          r_next.src_mode = w[tcd_pkg::MODE_SRC_LSB +: 2];
          r_next.style = w[tcd_pkg::MODE_STYLE_BIT];
        end
        tcd_pkg::IDX_WAIT_REQ_CTRL: begin
          r_next.mem_wait = w[tcd_pkg::CTL_MEM_WAIT_LSB +: 2];
          r_next.io_wait = w[tcd_pkg::CTL_IO_WAIT_LSB +: 2];
          r_next.sense = w[tcd_pkg::CTL_SENSE_LSB +: 2];
          r_next.dir = w[tcd_pkg::CTL_DIR_LSB +: 2];
        end
        tcd_pkg::IDX_IRQ_CLEAR: done_clr = w[1:0];
        tcd_pkg::IDX_IRQ_ENABLE: r_next.irq_en = w[1:0];
        default: r_next.done = r_next.done;
      endcase
    end

    // Halt stops new transfers, and a started transfer still completes; channels restart only when software re-enables
    if (master_halt) begin
      r_next.master = 1'b0;
    end
    // A completion in the clear cycle survives the clear
    r_next.done = (r_reg.done & ~done_clr) | done_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.mem_wait <= tcd_pkg::WAIT_REQ_RESET[tcd_pkg::CTL_MEM_WAIT_LSB +: 2];
      r_reg.io_wait <= tcd_pkg::WAIT_REQ_RESET[tcd_pkg::CTL_IO_WAIT_LSB +: 2];
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pslverr = r_reg.pslverr;
  // Read data is staged in the setup phase, so every access ends in one cycle
  assign pready = 1'b1;
  assign bus = r_reg.bus;
  // Level output: stays high until software clears the done bit or masks it
  assign irq = |(r_reg.done & r_reg.irq_en);

endmodule

`default_nettype wire

/* hdl/tcd_pkg.sv */
// Shared constants, types and helpers for the two-channel DMA and wait-state block
package tcd_pkg;

  // Register indices; byte address on APB is four times the index
  localparam logic [5:0] IDX_CH0_SRC_LOW = 6'h20;
  localparam logic [5:0] IDX_CH0_SRC_HIGH = 6'h21;
  localparam logic [5:0] IDX_CH0_SRC_BANK = 6'h22;
  localparam logic [5:0] IDX_CH0_DEST_LOW = 6'h23;
  localparam logic [5:0] IDX_CH0_DEST_HIGH = 6'h24;
  localparam logic [5:0] IDX_CH0_DEST_BANK = 6'h25;
  localparam logic [5:0] IDX_CH0_COUNT_LOW = 6'h26;
  localparam logic [5:0] IDX_CH0_COUNT_HIGH = 6'h27;
  localparam logic [5:0] IDX_CH1_MEM_LOW = 6'h28;
  localparam logic [5:0] IDX_CH1_MEM_HIGH = 6'h29;
  localparam logic [5:0] IDX_CH1_MEM_BANK = 6'h2a;
  localparam logic [5:0] IDX_CH1_IO_LOW = 6'h2b;
  localparam logic [5:0] IDX_CH1_IO_HIGH = 6'h2c;
  localparam logic [5:0] IDX_CH1_COUNT_LOW = 6'h2e;
  localparam logic [5:0] IDX_CH1_COUNT_HIGH = 6'h2f;
  localparam logic [5:0] IDX_STATUS_ENABLE = 6'h30;
  localparam logic [5:0] IDX_CH0_MODE = 6'h31;
  localparam logic [5:0] IDX_WAIT_REQ_CTRL = 6'h32;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h38;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h39;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h3a;

  // Status/enable register fields
  localparam int ST_CH1_ENABLE = 7;
  localparam int ST_CH0_ENABLE = 6;
  localparam int ST_CH1_GATE = 5;
  localparam int ST_CH0_GATE = 4;
  localparam int ST_CH1_IRQ_EN = 3;
  localparam int ST_CH0_IRQ_EN = 2;
  localparam int ST_MASTER = 0;
  localparam logic [7:0] STATUS_RESET = 8'h32;

  // Channel 0 mode register fields
  localparam int MODE_DEST_LSB = 4;
  localparam int MODE_SRC_LSB = 2;
  localparam int MODE_STYLE_BIT = 1;
  localparam logic [7:0] CH0_MODE_RESET = 8'hc1;

  // Wait and request control fields
  localparam int CTL_MEM_WAIT_LSB = 6;
  localparam int CTL_IO_WAIT_LSB = 4;
  localparam int CTL_SENSE_LSB = 2;
  localparam int CTL_DIR_LSB = 0;
  localparam logic [7:0] WAIT_REQ_RESET = 8'hf0;

  // Channel 0 addressing modes
  localparam logic [1:0] AMODE_INC = 2'b00;
  localparam logic [1:0] AMODE_DEC = 2'b01;
  localparam logic [1:0] AMODE_FIXED = 2'b10;
  localparam logic [1:0] AMODE_IO = 2'b11;

  // Request sources picked by the bank low bits
  localparam logic [1:0] RSRC_EXT = 2'b00;
  localparam logic [1:0] RSRC_SER0 = 2'b01;
  localparam logic [1:0] RSRC_SER1 = 2'b10;

  localparam int MEM_ADDR_W = 19;

  typedef enum logic [1:0] {
    TCD_IDLE,
    TCD_READ,
    TCD_WRITE,
    TCD_YIELD
  } tcd_fsm_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic write;
    logic [MEM_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } tcd_bus_t;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic latched;
  } tcd_sense_t;

  typedef struct packed {
    logic [MEM_ADDR_W-1:0] ch0_src;
    logic [MEM_ADDR_W-1:0] ch0_dest;
    logic [15:0] ch0_count;
    logic [MEM_ADDR_W-1:0] ch1_mem;
    logic [15:0] ch1_io;
    logic [15:0] ch1_count;
    logic [1:0] enable;
    logic [1:0] irq_en;
    logic master;
    logic [1:0] dest_mode;
    logic [1:0] src_mode;
    logic style;
    logic [1:0] mem_wait;
    logic [1:0] io_wait;
    logic [1:0] sense;
    logic [1:0] dir;
    logic [1:0] done;
    logic [31:0] prdata;
    logic pslverr;
    tcd_fsm_t fsm;
    logic chan;
    logic [2:0] wait_cnt;
    logic [1:0] consume;
    tcd_bus_t bus;
  } tcd_state_t;

  // Wait states for one bus cycle, memory or I/O
  function automatic logic [2:0] cycle_waits(input logic io, input logic [1:0] mw,
                                              input logic [1:0] iw);
    if (!io) begin
      return {1'b0, mw};
    end else if (iw == 2'b00) begin
      return 3'd0;
    end else begin
      return {1'b0, iw} + 3'd1;
    end
  endfunction

endpackage

/* hdl/tcd_req_sense.sv */
// Request pin synchroniser with selectable level or edge detection
`timescale 1ns/1ns
`default_nettype none

module tcd_req_sense (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_pin,
  input wire logic edge_mode,
  input wire logic consume,
  output logic pending
);

  tcd_pkg::tcd_sense_t s_reg;
  tcd_pkg::tcd_sense_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.sync = {s_reg.sync[1:0], req_pin};
    if (s_reg.sync[1] == s_reg.sync[2]) begin
      s_next.level = s_reg.sync[2];
    end
    if (consume) begin
      s_next.latched = 1'b0;
    end
    // A new edge in the consume cycle is kept
    if (s_next.level && !s_reg.level) begin
      s_next.latched = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pending = edge_mode ? s_reg.latched : s_reg.level;

endmodule

`default_nettype wire

/* verif/tcd_dma_ctrl_props.sv */
// Port-level assertions for the DMA controller
`timescale 1ns/1ns
`default_nettype none

module tcd_dma_ctrl_props #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire tcd_pkg::tcd_bus_t bus,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ctl;
  logic [1:0] ie;
  logic [3:0] rd_len, wr_len;
  logic [2:0] w_now;
  logic acc;
  assign acc = psel && penable && pwrite && paddr[1:0] == 2'b00;
  // Shadow of the wait fields, so cycle lengths are judged without the design's state
  assign w_now = bus.is_io ? (ctl[5:4] == 2'b00 ? 3'd0 : {1'b0, ctl[5:4]} + 3'd1)
                           : {1'b0, ctl[7:6]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'hf0;
      ie <= 2'b00;
      rd_len <= 4'h0;
      wr_len <= 4'h0;
    end else begin
      if (acc && paddr[7:2] == tcd_pkg::IDX_WAIT_REQ_CTRL) ctl <= pwdata[7:0];
      if (acc && paddr[7:2] == tcd_pkg::IDX_STATUS_ENABLE) ie <= pwdata[3:2];
      if (acc && paddr[7:2] == tcd_pkg::IDX_IRQ_ENABLE) ie <= pwdata[1:0];
      rd_len <= (bus.valid && !bus.write) ? rd_len + 4'h1 : 4'h0;
      wr_len <= (bus.valid && bus.write) ? wr_len + 4'h1 : 4'h0;
    end
  end
  sequence s_read_end;
    bus.valid && !bus.write ##1 !(bus.valid && !bus.write);
  endsequence
  sequence s_write_end;
    bus.valid && bus.write ##1 !(bus.valid && bus.write);
  endsequence
  property p_read_len;
    s_read_end |-> rd_len == {1'b0, $past(w_now)} + 4'h1;
  endproperty
  property p_write_len;
    s_write_end |-> wr_len == {1'b0, $past(w_now)} + 4'h1;
  endproperty
  property p_read_to_write;
    s_read_end |-> bus.valid && bus.write;
  endproperty
  property p_read_first;
    $rose(bus.valid) |-> !bus.write;
  endproperty
  property p_write_gap;
    bus.valid && bus.write |=> !bus.valid || bus.write;
  endproperty
  property p_addr_stable;
    bus.valid && $past(bus.valid) && bus.write == $past(bus.write) |-> $stable(bus.addr);
  endproperty
  property p_irq_masked;
    irq |-> ie != 2'b00;
  endproperty
  property p_upper_zero;
    psel && penable |-> prdata[31:8] == 24'h0 && pready;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read cycle length wrong");
  a_write_len: assert property (p_write_len) else $error("write cycle length wrong");
  a_read_to_write: assert property (p_read_to_write) else $error("read not followed by write");
  a_read_first: assert property (p_read_first) else $error("transfer began with write");
  a_write_gap: assert property (p_write_gap) else $error("no idle after write");
  a_addr_stable: assert property (p_addr_stable) else $error("bus address moved");
  a_irq_masked: assert property (p_irq_masked) else $error("irq while disabled");
  a_upper_zero: assert property (p_upper_zero) else $error("bad read word");
endmodule

bind tcd_dma_ctrl tcd_dma_ctrl_props #(.ADDR_W(ADDR_W)) props_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .bus(bus), .irq(irq));

`default_nettype wire

/* verif/tcd_mem_model.sv */
// Memory and I/O devices answering the engine's bus cycles
`timescale 1ns/1ns
`default_nettype none

module tcd_mem_model (
  input wire logic pclk,
  input wire tcd_pkg::tcd_bus_t bus,
  output logic [7:0] bus_rdata,
  output logic [7:0] seen_data,
  output logic seen_io,
  output logic [18:0] seen_addr
);
  logic [7:0] held;
  logic rd;
  assign rd = bus.valid && !bus.write;
  // Released data bus shows the inverse of its last value, never a stale match
  assign bus_rdata = rd ? (bus.addr[7:0] ^ (bus.is_io ? 8'ha5 : 8'h5a)) : ~held;
  always_ff @(posedge pclk) begin
    held <= bus_rdata;
    if (bus.valid && bus.write) begin
      seen_data <= bus.wdata;
      seen_io <= bus.is_io;
      seen_addr <= bus.addr;
    end
  end
endmodule

`default_nettype wire

/* verif/two_channel_dma_wait_control_bench.sv */
// Register, channel 0 and channel 1 transfer tests for the DMA controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end

module two_channel_dma_wait_control_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, halt, last_err, seen_io;
  logic [7:0] paddr, rdata, seen_data, v;
  logic [31:0] pwdata, prdata;
  logic [1:0] req, d, ser;
  logic [18:0] seen_addr;
  tcd_pkg::tcd_bus_t bus;
  int mismatches, n_checks, i, k;

  tcd_dma_ctrl #(.ADDR_W(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .transfer_request_input(req),
    .serial_rx_ready(ser), .serial_tx_ready(2'b00), .master_halt(halt), .bus(bus),
    .bus_rdata(rdata), .irq(irq));
  tcd_mem_model mem_u (.pclk(pclk), .bus(bus), .bus_rdata(rdata), .seen_data(seen_data),
    .seen_io(seen_io), .seen_addr(seen_addr));

  always #10 pclk = ~pclk;

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {a[5:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] r;
    xfer(1'b1, a, wd, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    xfer(1'b0, a, 8'h00, r);
    `CHK(r, e)
  endtask
  task automatic irq_is(input logic e);
    @(negedge pclk);
    `CHK(irq, e)
    @(posedge pclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    req = 0; halt = 0; ser = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h30, 8'h32);
    rd_chk(8'h31, 8'hc1);
    rd_chk(8'h32, 8'hf0);
    for (i = 0; i < 10; i++) begin
      v = 8'hc8 + 8'(i);
      rd_chk(8'h26 + 8'(i), 8'h00);
      wr(8'h26 + 8'(i), v);
      // Index 0x2d is a hole in the map and must refuse
      rd_chk(8'h26 + 8'(i), i == 7 ? 8'h00 : i == 4 ? (v & 8'h07) : v);
      `CHK(last_err, i == 7)
    end
    wr(8'h31, 8'hff);
    rd_chk(8'h31, 8'hff);
    wr(8'h31, 8'h14);
    rd_chk(8'h31, 8'hd5);
    wr(8'h30, 8'hfc);
    rd_chk(8'h30, 8'h3e);
    wr(8'h30, 8'h00);
    for (k = 0; k < 4; k++) begin
      d = 2'(k);
      // Every wait code and direction once; odd passes use edge sensing
      wr(8'h32, {d, d, d[0], 1'b0, d});
      wr(8'h28, 8'h80);
      wr(8'h29, 8'h00);
      wr(8'h2a, 8'h00);
      wr(8'h2b, 8'h40);
      wr(8'h2c, 8'h00);
      wr(8'h2e, 8'h01);
      wr(8'h2f, 8'h00);
      wr(8'h30, 8'h98);
      req <= 2'b10;
      for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge pclk);
      irq_is(1'b1);
      req <= 2'b00;
      `CHK(seen_io, !d[1])
      `CHK(seen_addr, d[1] ? 19'h00080 : 19'h00040)
      `CHK(seen_data, d[1] ? 8'he5 : 8'hda)
      rd_chk(8'h28, d[0] ? 8'h7f : 8'h81);
      rd_chk(8'h2b, 8'h40);
      rd_chk(8'h2e, 8'h00);
      rd_chk(8'h30, 8'h3b);
      rd_chk(8'h38, 8'h02);
      wr(8'h3a, 8'h00);
      irq_is(1'b0);
      wr(8'h3a, 8'h02);
      irq_is(1'b1);
      wr(8'h39, 8'h02);
      irq_is(1'b0);
      rd_chk(8'h38, 8'h00);
    end
    halt <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h30, 8'h3a);
    halt <= 1'b0;
    // Channel 0: I/O source paced by serial receive 0, memory destination counting up
    wr(8'h20, 8'h33);
    wr(8'h22, 8'h01);
    wr(8'h24, 8'h01);
    wr(8'h26, 8'h02);
    wr(8'h27, 8'h00);
    wr(8'h31, 8'h0c);
    wr(8'h30, 8'h64);
    repeat (20) @(posedge pclk);
    rd_chk(8'h26, 8'h02);
    ser <= 2'b01;
    for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge pclk);
    irq_is(1'b1);
    ser <= 2'b00;
    `CHK(seen_io, 1'b0)
    `CHK(seen_addr, 19'h00101)
    `CHK(seen_data, 8'h96)
    rd_chk(8'h20, 8'h33);
    rd_chk(8'h23, 8'h02);
    rd_chk(8'h30, 8'h37);
    results();
  end
endmodule

`default_nettype wire
